//--- hdl/src_pkg.sv
// Purpose: shared constants and types of the system reset controller
// Assumes: 100 MHz system clock, 32-bit AHB-Lite register access
// Notes: register byte address is four times the register index
package src_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // register indexes; byte address = index << ADDR_LSB
    localparam logic [7:0] IDX_FLAGS = 8'h00;
    localparam logic [7:0] IDX_SOFT = 8'h01;
    localparam logic [7:0] IDX_KEY = 8'h02;
    localparam int ADDR_LSB = 2;
    // cause flag positions
    localparam int FLAG_POR = 0;
    localparam int FLAG_BOD = 1;
    localparam int FLAG_PIN = 2;
    localparam int FLAG_WDT = 3;
    localparam int FLAG_SOFT = 4;
    localparam int FLAG_DBG = 5;
    localparam int NUM_SRC = 6;
    localparam logic [NUM_SRC-1:0] FLAGS_RESET = 6'h01;
    localparam logic [NUM_SRC-1:0] FLAGS_ALL = 6'h3F;
    localparam int SOFT_TRIG_BIT = 0;
    localparam int KEY_UNLOCK_BIT = 0;
    // unlock key value is arbitrary
    localparam logic [7:0] IO_KEY = 8'hA5;
    localparam logic [2:0] CCP_WINDOW_CYCLES = 3'h4;
    localparam logic [2:0] BOD_LEVEL_MIN = 3'h0;
    // timing
    localparam int INIT_TIME_NS = 640;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUT_STEP_US = 1000;
    localparam int SUT_STEP_CYCLES = SUT_STEP_US * 1000 / CLK_PERIOD_NS;
    localparam int SCAN_TIME_US = 100;
    localparam int SCAN_CYCLES = SCAN_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int TIMER_W = 24;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_INIT = 3'b100
    } src_state_e;

    typedef struct packed {
        logic bod_enable;
        logic [2:0] bod_level;
        logic pin_reset_en;
        logic [2:0] startup_delay;
        logic scan_at_start;
    } src_fuse_s;

    typedef struct packed {
        logic por_low;
        logic bod_low;
        logic reset_pin_n;
        logic wdt_timeout;
        logic debug_req;
    } src_req_s;
endpackage

//--- hdl/src_init_timer.sv
// Purpose: down counter timing the internal initialization phase
// Assumes: load value of at least one
// Notes: busy_q is high from the edge after load until the count runs out
`timescale 1ns/100ps
`default_nettype none
module src_init_timer #(
    parameter int W = 24
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy_q
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic busy_d;

    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_val;
        end else if (count_q != '0) begin
            count_d = count_q - W'(1);
        end
        busy_d = (count_d != '0);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            busy_q <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q <= busy_d;
        end
    end
endmodule
`default_nettype wire

//--- hdl/src_reset_ctrl.sv
// Purpose: merges reset sources into the device reset and records the cause
// Assumes: AHB-Lite slave, single word transfers, fuses stable while running
// Notes: reads take one wait state, writes none; response always OKAY
`timescale 1ns/100ps
`default_nettype none
// Contract
// - controller always on, some sources need enabling
// - fuse and signature reload after every reset
// - cause flags readable at register zero
// - power-on always enabled, holds until init done
// - supply drop reasserts reset at once
// - unused brown-out forced to minimum level
// - enabled low pin holds reset until high
// - watchdog timeout issues a reset
// - soft trigger write starts full reset sequence
// - supply resets also reset the debug port
// - hold while sources active, then initialize
// - startup delay added only for supply resets
// - memory scan at start lengthens initialization
// - works and accepts requests in all modes
// - unprotected soft register writes are ignored
// - six flags: debug, soft, watchdog, pin, brown-out, power-on
// - writing one clears flag; power-on clears others
// - after power-on no other flag until booted
// - soft trigger always reads back zero
module src_reset_ctrl
    import src_pkg::*;
#(
    parameter int STEP_CYCLES = SUT_STEP_CYCLES,
    parameter int MEMSCAN_CYCLES = SCAN_CYCLES,
    parameter int BASE_CYCLES = INIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire src_fuse_s fuse,
    input wire src_req_s req,
    output logic sys_reset_q,
    output logic debug_reset_q,
    output logic fuse_reload_q,
    output logic [2:0] bod_level_q
);
    // pin synchronizer
    logic pin_meta_q;
    logic pin_sync_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
        end else begin
            pin_meta_q <= req.reset_pin_n;
            pin_sync_q <= pin_meta_q;
        end
    end

    // source vector, gated by fuse enables
    logic soft_req_q;
    logic [NUM_SRC-1:0] src_vec;
    logic any_src;
    logic supply_src;

    always_comb begin
        src_vec = '0;
        src_vec[FLAG_POR] = req.por_low;
        src_vec[FLAG_BOD] = fuse.bod_enable & req.bod_low;
        src_vec[FLAG_PIN] = fuse.pin_reset_en & ~pin_sync_q;
        src_vec[FLAG_WDT] = req.wdt_timeout;
        src_vec[FLAG_SOFT] = soft_req_q;
        src_vec[FLAG_DBG] = req.debug_req;
        any_src = |src_vec;
        supply_src = src_vec[FLAG_POR] | src_vec[FLAG_BOD];
    end

    // bus and registers
    logic dp_valid_q;
    logic dp_valid_d;
    logic dp_write_q;
    logic dp_write_d;
    logic [7:0] dp_idx_q;
    logic [7:0] dp_idx_d;
    logic rd_pend_q;
    logic rd_pend_d;
    logic hready_d;
    logic [31:0] hrdata_d;
    logic [NUM_SRC-1:0] flags_q;
    logic [NUM_SRC-1:0] flags_d;
    logic [2:0] unlock_q;
    logic [2:0] unlock_d;
    logic soft_req_d;
    logic boot_done_q;
    logic boot_done_d;
    logic [NUM_SRC-1:0] flag_set;
    logic [NUM_SRC-1:0] flag_clr;
    logic wr_ok;
    logic boot_end;
    logic [2:0] bod_level_d;

    function automatic logic [31:0] read_mux(input logic [7:0] idx,
                                             input logic [NUM_SRC-1:0] flg,
                                             input logic unl);
        logic [31:0] v;
        v = '0;
        if (idx == IDX_FLAGS) begin
            v[NUM_SRC-1:0] = flg;
        end else if (idx == IDX_KEY) begin
            v[KEY_UNLOCK_BIT] = unl;
        end
        // soft register and unmapped read as zero
        return v;
    endfunction

    always_comb begin
        dp_valid_d = 1'b0;
        dp_write_d = dp_write_q;
        dp_idx_d = dp_idx_q;
        if (hsel && htrans[1] && hready) begin
            dp_valid_d = 1'b1;
            dp_write_d = hwrite;
            dp_idx_d = haddr[ADDR_LSB+7:ADDR_LSB];
        end
        // one wait state lets a write in the previous data phase land first
        rd_pend_d = dp_valid_d & ~dp_write_d;
        hready_d = ~rd_pend_d;
        hrdata_d = hrdata;
        if (rd_pend_q) begin
            hrdata_d = read_mux(dp_idx_q, flags_q, unlock_q != 3'h0);
        end
        wr_ok = dp_valid_q & dp_write_q;
        unlock_d = (unlock_q != 3'h0) ? unlock_q - 3'h1 : 3'h0;
        soft_req_d = 1'b0;
        flag_clr = '0;
        if (wr_ok && dp_idx_q == IDX_KEY && hwdata[7:0] == IO_KEY) begin
            unlock_d = CCP_WINDOW_CYCLES;
        end
        if (wr_ok && dp_idx_q == IDX_SOFT) begin
            // a locked write changes nothing
            if (unlock_q != 3'h0) begin
                soft_req_d = hwdata[SOFT_TRIG_BIT];
                unlock_d = 3'h0;
            end
        end
        if (wr_ok && dp_idx_q == IDX_FLAGS) begin
            flag_clr = hwdata[NUM_SRC-1:0];
        end
        boot_done_d = boot_done_q | boot_end;
        flag_set = boot_done_q ? src_vec : (src_vec & FLAGS_RESET);
        flags_d = (flags_q & ~flag_clr) | flag_set;
        if (src_vec[FLAG_POR]) begin
            flags_d = FLAGS_RESET;
            boot_done_d = 1'b0;
        end
        bod_level_d = fuse.bod_enable ? fuse.bod_level : BOD_LEVEL_MIN;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_idx_q <= 8'h00;
            rd_pend_q <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            flags_q <= FLAGS_RESET;
            unlock_q <= 3'h0;
            soft_req_q <= 1'b0;
            boot_done_q <= 1'b0;
            bod_level_q <= BOD_LEVEL_MIN;
        end else begin
            dp_valid_q <= dp_valid_d;
            dp_write_q <= dp_write_d;
            dp_idx_q <= dp_idx_d;
            rd_pend_q <= rd_pend_d;
            hreadyout <= hready_d;
            hresp <= 1'b0;
            hrdata <= hrdata_d;
            flags_q <= flags_d;
            unlock_q <= unlock_d;
            soft_req_q <= soft_req_d;
            boot_done_q <= boot_done_d;
            bod_level_q <= bod_level_d;
        end
    end

    // sequencer; no sleep input gates it, so it runs in every mode
    src_state_e state_q;
    src_state_e state_d;
    logic supply_q;
    logic supply_d;
    logic timer_load;
    logic timer_busy;
    logic [TIMER_W-1:0] init_len;
    logic sys_reset_d;
    logic debug_reset_d;
    logic fuse_reload_d;

    function automatic logic [TIMER_W-1:0] init_cycles(input logic supply,
                                                      input logic [2:0] startup_delay_field,
                                                      input logic scan);
        logic [TIMER_W-1:0] n;
        n = TIMER_W'(BASE_CYCLES);
        if (supply) begin
            n = n + TIMER_W'(startup_delay_field) * TIMER_W'(STEP_CYCLES);
        end
        if (scan) begin
            n = n + TIMER_W'(MEMSCAN_CYCLES);
        end
        return n;
    endfunction

    always_comb begin
        state_d = state_q;
        supply_d = supply_q | supply_src;
        timer_load = 1'b0;
        fuse_reload_d = 1'b0;
        boot_end = 1'b0;
        init_len = init_cycles(supply_d, fuse.startup_delay, fuse.scan_at_start);
        unique case (state_q)
            ST_RUN: begin
                if (any_src) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!any_src) begin
                    state_d = ST_INIT;
                    timer_load = 1'b1;
                    fuse_reload_d = 1'b1;
                end
            end
            ST_INIT: begin
                if (any_src) begin
                    state_d = ST_HOLD;
                end else if (!timer_busy) begin
                    state_d = ST_RUN;
                    boot_end = 1'b1;
                end
            end
        endcase
        if (state_d == ST_RUN) begin
            supply_d = 1'b0;
        end
        sys_reset_d = (state_d != ST_RUN);
        debug_reset_d = sys_reset_d & supply_d;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_HOLD;
            supply_q <= 1'b1;
            sys_reset_q <= 1'b1;
            debug_reset_q <= 1'b1;
            fuse_reload_q <= 1'b0;
        end else begin
            state_q <= state_d;
            supply_q <= supply_d;
            sys_reset_q <= sys_reset_d;
            debug_reset_q <= debug_reset_d;
            fuse_reload_q <= fuse_reload_d;
        end
    end

    src_init_timer #(
        .W(TIMER_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(timer_load),
        .load_val(init_len),
        .busy_q(timer_busy)
    );
endmodule
`default_nettype wire

//--- bench/src_monitor.sv
// Purpose: port-level checks of the reset controller
// Assumes: one slave, hready tied to hreadyout
// Notes: init bound uses the smallest base count
`timescale 1ns/100ps
`default_nettype none
module src_monitor
    import src_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire src_fuse_s fuse,
    input wire src_req_s req,
    input wire logic sys_reset_q,
    input wire logic debug_reset_q,
    input wire logic fuse_reload_q,
    input wire logic [2:0] bod_level_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic rd_go = hsel && htrans[1] && hready && !hwrite;
    property p_rd_wait; rd_go |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_soft_zero; rd_go && haddr[9:2] == IDX_SOFT |=> ##1 hrdata == 32'h0; endproperty
    a_soft_zero: assert property (p_soft_zero) else $error("trigger read not zero");
    property p_por; req.por_low |=> sys_reset_q && debug_reset_q; endproperty
    a_por: assert property (p_por) else $error("supply drop not held");
    property p_wdt; req.wdt_timeout |=> sys_reset_q; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog not taken");
    property p_pin; fuse.pin_reset_en && !req.reset_pin_n |-> ##[1:4] sys_reset_q; endproperty
    a_pin: assert property (p_pin) else $error("pin not taken");
    property p_user;
        !sys_reset_q && req.wdt_timeout && !req.por_low && !req.bod_low |=> !debug_reset_q;
    endproperty
    a_user: assert property (p_user) else $error("debug port reset by user");
    property p_bod;
        $past(rst_n) |-> bod_level_q == ($past(fuse.bod_enable) ? $past(fuse.bod_level) : 3'h0);
    endproperty
    a_bod: assert property (p_bod) else $error("trigger level wrong");
    property p_reload; fuse_reload_q |=> !fuse_reload_q; endproperty
    a_reload: assert property (p_reload) else $error("reload not a pulse");
    property p_init; fuse_reload_q |-> sys_reset_q [*4]; endproperty
    a_init: assert property (p_init) else $error("init too short");
    property p_fall; $fell(sys_reset_q) |-> !$past(req.por_low) && !$past(req.wdt_timeout); endproperty
    a_fall: assert property (p_fall) else $error("release with source on");
    cover property ($rose(sys_reset_q));
    cover property (rd_go);
    cover property (fuse_reload_q);
endmodule
bind src_reset_ctrl src_monitor u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .fuse(fuse), .req(req), .sys_reset_q(sys_reset_q),
    .debug_reset_q(debug_reset_q), .fuse_reload_q(fuse_reload_q), .bod_level_q(bod_level_q)
);
`default_nettype wire

//--- bench/src_far_model.sv
// Purpose: supply monitors, reset pin, watchdog and debugger
// Assumes: one request bit per cause flag position
// Notes: levels only, so held as long as commanded
`timescale 1ns/100ps
`default_nettype none
module src_far_model
    import src_pkg::*;
(
    input wire logic [NUM_SRC-1:0] want,
    output wire src_req_s req
);
    assign req.por_low = want[FLAG_POR];
    assign req.bod_low = want[FLAG_BOD];
    assign req.reset_pin_n = !want[FLAG_PIN];
    assign req.wdt_timeout = want[FLAG_WDT];
    // only the bench acting as debugger raises this
    assign req.debug_req = want[FLAG_DBG];
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: directed register and reset-source checks
// Assumes: short init counts set at the instance
// Notes: user-reset length only bounded from above
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import src_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire logic hready;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic sys_reset_q;
    wire logic debug_reset_q;
    wire logic fuse_reload_q;
    wire logic [2:0] bod_level_q;
    wire src_req_s req;
    src_fuse_s fuse = '{1'b0, 3'h5, 1'b0, 3'h3, 1'b1};
    logic [NUM_SRC-1:0] want = '0;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int srcs[4] = '{FLAG_BOD, FLAG_PIN, FLAG_WDT, FLAG_DBG};
    src_far_model far (.want(want), .req(req));
    src_reset_ctrl #(.STEP_CYCLES(10), .MEMSCAN_CYCLES(5), .BASE_CYCLES(4)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .fuse(fuse), .req(req), .sys_reset_q(sys_reset_q),
        .debug_reset_q(debug_reset_q), .fuse_reload_q(fuse_reload_q), .bod_level_q(bod_level_q)
    );
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait; sel 0 waits for bus ready, 1 for reset level v
    task automatic hop(input bit sel, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((sel ? sys_reset_q : hready) !== v && n < 200);
        if (n >= 200) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        hop(0, 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        hop(0, 1'b1);
        rd = hrdata;
        chk("response", hresp, 32'h0);
    endtask
    initial begin
        int t0;
        repeat (3) @(posedge sys_clk);
        chk("debug reset", debug_reset_q, 32'h1);
        rst_n <= 1'b1;
        t0 = cyc;
        bus(0, IDX_FLAGS, 32'h0);
        chk("flags at boot", rd, 32'h1);
        bus(0, 8'h3F, 32'h0);
        chk("unmapped", rd, 32'h0);
        hop(1, 1'b0);
        chk("boot length", 32'(cyc - t0 >= 39), 32'h1);
        chk("unused level", bod_level_q, 32'h0);
        bus(1, IDX_SOFT, 32'h1);
        repeat (4) @(posedge sys_clk);
        chk("unkeyed write", sys_reset_q, 32'h0);
        bus(1, IDX_KEY, {24'h0, IO_KEY});
        bus(1, IDX_SOFT, 32'h1);
        hop(1, 1'b1);
        chk("soft debug", debug_reset_q, 32'h0);
        hop(1, 1'b0);
        bus(0, IDX_FLAGS, 32'h0);
        chk("soft flag", rd, 32'h11);
        bus(0, IDX_SOFT, 32'h0);
        chk("trigger read", rd, 32'h0);
        want[FLAG_PIN] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("pin disabled", sys_reset_q, 32'h0);
        want <= '0;
        // let the pin synchronizer see the released pin before it is enabled
        repeat (3) @(posedge sys_clk);
        fuse <= '{1'b1, 3'h5, 1'b1, 3'h3, 1'b1};
        bus(1, IDX_FLAGS, {26'h0, FLAGS_ALL});
        bus(0, IDX_FLAGS, 32'h0);
        chk("flags cleared", rd, 32'h0);
        chk("level used", bod_level_q, 32'h5);
        foreach (srcs[i]) begin
            want[srcs[i]] <= 1'b1;
            hop(1, 1'b1);
            @(posedge sys_clk);
            chk("debug port", debug_reset_q, 32'(srcs[i] == FLAG_BOD));
            want[srcs[i]] <= 1'b0;
            t0 = cyc;
            hop(1, 1'b0);
            chk("init length", 32'(cyc - t0 >= 39), 32'(srcs[i] == FLAG_BOD));
            bus(0, IDX_FLAGS, 32'h0);
            chk("cause flag", rd, 32'h1 << srcs[i]);
            if (srcs[i] != FLAG_DBG) begin
                bus(1, IDX_FLAGS, 32'h1 << srcs[i]);
            end
        end
        want[FLAG_POR] <= 1'b1;
        hop(1, 1'b1);
        want[FLAG_POR] <= 1'b0;
        hop(1, 1'b0);
        bus(0, IDX_FLAGS, 32'h0);
        chk("power-on flags", rd, 32'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
